// File: logic/sso_pkg.sv
// Package of the servo status-output block: register map, reset values,
// function codes, timing constants and carrier types.
// Assumes a single 125 MHz control clock and a plain register port.
package sso_pkg;

  // ****************************************************************
  // Register bus geometry
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_FSEL0  = 8'h00;  // Selector, terminal 1; four more follow
  localparam logic [7:0] OFS_POL    = 8'h14;  // Polarity, one bit per terminal
  localparam logic [7:0] OFS_LMASK  = 8'h18;  // Low input default mask
  localparam logic [7:0] OFS_HMASK  = 8'h1C;  // High input default mask
  localparam logic [7:0] OFS_THR    = 8'h20;  // Settle threshold, pulses
  localparam logic [7:0] OFS_CMODE  = 8'h24;  // Completion mode
  localparam logic [7:0] OFS_HOLD   = 8'h28;  // Settle hold time, ms
  localparam logic [7:0] OFS_ROT    = 8'h2C;  // Rotation threshold, rpm
  localparam logic [7:0] OFS_MATCH  = 8'h30;  // Speed match width, rpm
  localparam logic [7:0] OFS_ARR    = 8'h34;  // Speed arrival width, rpm
  localparam logic [7:0] OFS_CTRL   = 8'h38;  // Restart command
  localparam logic [7:0] OFS_ISTAT  = 8'h3C;  // Event status, write one to clear
  localparam logic [7:0] OFS_IMASK  = 8'h40;  // Event mask
  localparam logic [7:0] OFS_STATE  = 8'h44;  // Live flags and contacts
  localparam logic [7:0] FSEL_STEP  = 8'h04;  // Spacing of selectors

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_RESTART_BIT = 0;
  localparam int EV_SETTLED       = 0;
  localparam int EV_ROT           = 1;
  localparam int EV_MATCH         = 2;
  localparam int EV_ARR           = 3;
  localparam int N_EV             = 4;
  localparam int STATE_DO_LSB     = 4;  // Contacts sit above the four flags

  // ****************************************************************
  // Terminal counts and reset values
  // ****************************************************************
  localparam int N_DO = 5;
  localparam logic [4:0] FSEL_RST [N_DO] = '{5'h01, 5'h04, 5'h07, 5'h02, 5'h09};
  localparam logic [4:0]  POL_RST   = 5'h00;
  localparam logic [15:0] LMASK_RST = 16'h0000;
  localparam logic [15:0] HMASK_RST = 16'h0000;
  localparam logic [15:0] THR_RST   = 16'h0064;
  localparam logic [15:0] HOLD_RST  = 16'h0001;
  localparam logic [9:0]  ROT_RST   = 10'h014;
  localparam logic [9:0]  MATCH_RST = 10'h032;
  localparam logic [13:0] ARR_RST   = 14'h0064;

  // ****************************************************************
  // Function codes produced by this block
  // ****************************************************************
  localparam logic [4:0] FN_ROT     = 5'h03;
  localparam logic [4:0] FN_SETTLED = 5'h05;
  localparam logic [4:0] FN_MATCH   = 5'h06;
  localparam logic [4:0] FN_ARR     = 5'h08;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    CM_DEV      = 3'h0,  // Deviation only
    CM_CMD      = 3'h1,  // Plus command zero
    CM_CMD_HOLD = 3'h2,  // Plus command zero, stretched
    CM_FILT     = 3'h3,  // Plus filtered command zero
    CM_DEV_ZS   = 3'h4,
    CM_CMD_ZS   = 3'h5,
    CM_HOLD_ZS  = 3'h6,
    CM_FILT_ZS  = 3'h7
  } sso_cmode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sso_reg_req_t;

  typedef struct packed {
    logic signed [31:0] pos_dev;       // Position deviation, pulses
    logic signed [31:0] pos_cmd;       // Position command this cycle
    logic signed [31:0] pos_cmd_filt;  // Command after filtering
    logic               zero_speed;    // Zero-speed indication
    logic signed [15:0] speed_fb;      // Motor speed, rpm
    logic signed [15:0] speed_ref;     // Speed command, rpm
    logic               speed_mode;    // Speed control mode active
  } sso_motion_t;

endpackage

// File: logic/sso_ms_tick.sv
// Millisecond tick generator for the settle hold timer.
// Assumes the free-running control clock.
`timescale 1ns/100ps
`default_nettype none
module sso_ms_tick #(
  parameter int unsigned CYC = 125000
) (
  input  wire logic mclk,
  input  wire logic resetn,
  output var  logic tick
);

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  localparam int CW = (CYC > 1) ? $clog2(CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  logic [CW-1:0] cnt_ff;   // Cycle count within a millisecond
  logic          tick_ff;  // One-cycle tick
  logic          wrap;     // Last cycle of the millisecond

  assign wrap = (cnt_ff == LAST);
  assign tick = tick_ff;

  // Count and pulse once per period
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= wrap ? '0 : cnt_ff + 1'b1;
      tick_ff <= wrap;
    end
  end

endmodule // sso_ms_tick
`default_nettype wire

// File: logic/sso_out_map.sv
// Per-terminal function selection and polarity for the output contacts.
// Assumes status bit 0 is held inactive by the caller.
`timescale 1ns/100ps
`default_nettype none
module sso_out_map #(
  parameter int N = 5
) (
  input  wire logic [31:0]       status,
  input  wire logic [N-1:0][4:0] fsel,
  input  wire logic [N-1:0]      pol,
  output var  logic [N-1:0]      contact
);

  // ****************************************************************
  // Select then invert, one terminal per pass
  // ****************************************************************
  for (genvar i = 0; i < N; i++) begin : g_term
    // Inversion acts on the selected function's state
    assign contact[i] = status[fsel[i]] ^ pol[i];
  end

endmodule // sso_out_map
`default_nettype wire

// File: logic/sso_top.sv
// Status-output logic of a servo drive: five output contacts, input
// defaults for unassigned functions, settle and speed flags, events.
// Assumes synchronous inputs on mclk and a plain register port.
`timescale 1ns/100ps
`default_nettype none
module sso_top #(
  parameter int unsigned CYC_PER_MS = sso_pkg::CYC_PER_MS
) (
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire sso_pkg::sso_reg_req_t reg_req,
  output var  logic [31:0]           rdata,
  input  wire sso_pkg::sso_motion_t  motion,
  input  wire logic [31:0]           func_status,
  input  wire logic [31:0]           input_assigned,
  input  wire logic [31:0]           input_level,
  output var  logic [31:0]           input_function,
  output var  logic [4:0]            digital_output,
  output var  logic                  position_settled_flag,
  output var  logic                  rotation_detect_flag,
  output var  logic                  speed_match_flag,
  output var  logic                  speed_arrival_flag,
  output var  logic                  irq
);
  import sso_pkg::*;

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (CYC_PER_MS < 2) begin : g_bad_ms
    $error("CYC_PER_MS must be at least 2");
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [N_DO-1:0][4:0] fsel_ff;      // Written selectors
  logic [N_DO-1:0][4:0] fsel_act_ff;  // Selectors in force
  logic [N_DO-1:0]      pol_ff;       // Polarity, in force at once
  logic [15:0]          lmask_ff;     // Written low mask
  logic [15:0]          lmask_act_ff; // Low mask in force
  logic [15:0]          hmask_ff;     // Written high mask
  logic [15:0]          hmask_act_ff; // High mask in force
  logic [15:0]          thr_ff;       // Settle threshold
  sso_cmode_t           cmode_ff;     // Completion mode
  logic [15:0]          hold_ff;      // Hold time, ms
  logic [9:0]           rot_ff;       // Rotation threshold
  logic [9:0]           match_ff;     // Match width
  logic [13:0]          arr_ff;       // Arrival width
  logic [N_EV-1:0]      istat_ff;     // Sticky events
  logic [N_EV-1:0]      imask_ff;     // Event enables
  logic [31:0]          rdata_ff;     // Read data
  logic                 irq_ff;       // Interrupt line

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic       wr     = reg_req.wr;
  wire logic [7:0] addr   = reg_req.addr;
  wire logic [31:0] wd    = reg_req.wdata;
  wire logic we_pol       = wr && (addr == OFS_POL);
  wire logic we_lmask     = wr && (addr == OFS_LMASK);
  wire logic we_hmask     = wr && (addr == OFS_HMASK);
  wire logic we_thr       = wr && (addr == OFS_THR);
  wire logic we_cmode     = wr && (addr == OFS_CMODE);
  wire logic we_hold      = wr && (addr == OFS_HOLD);
  wire logic we_rot       = wr && (addr == OFS_ROT);
  wire logic we_match     = wr && (addr == OFS_MATCH);
  wire logic we_arr       = wr && (addr == OFS_ARR);
  wire logic we_istat     = wr && (addr == OFS_ISTAT);
  wire logic we_imask     = wr && (addr == OFS_IMASK);
  // Restart applies the restart-effective settings
  wire logic restart      = wr && (addr == OFS_CTRL) && wd[CTRL_RESTART_BIT];
  logic [N_DO-1:0] we_fsel;  // One strobe per selector

  for (genvar i = 0; i < N_DO; i++) begin : g_fsel_dec
    assign we_fsel[i] = wr && (addr == OFS_FSEL0 + 8'(i * FSEL_STEP));
  end

  // ****************************************************************
  // Selectors: written copy and copy in force
  // ****************************************************************
  for (genvar i = 0; i < N_DO; i++) begin : g_fsel
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        fsel_ff[i]     <= FSEL_RST[i];
        fsel_act_ff[i] <= FSEL_RST[i];
      end else begin
        if (we_fsel[i])
          fsel_ff[i] <= wd[4:0];
        if (restart)
          fsel_act_ff[i] <= fsel_ff[i];
      end
    end
  end

  // ****************************************************************
  // Masks: take effect on restart
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lmask_ff     <= LMASK_RST;
      hmask_ff     <= HMASK_RST;
      lmask_act_ff <= LMASK_RST;
      hmask_act_ff <= HMASK_RST;
    end else begin
      if (we_lmask)
        lmask_ff <= {wd[15:1], 1'b0};   // Bit 0 reserved
      if (we_hmask)
        hmask_ff <= wd[15:0];
      if (restart) begin
        lmask_act_ff <= lmask_ff;
        hmask_act_ff <= hmask_ff;
      end
    end
  end

  // ****************************************************************
  // Immediate settings
  // ****************************************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pol_ff   <= POL_RST;
      thr_ff   <= THR_RST;
      cmode_ff <= CM_DEV;
      hold_ff  <= HOLD_RST;
    end else begin
      if (we_pol)
        pol_ff <= wd[N_DO-1:0];
      if (we_thr)
        thr_ff <= wd[15:0];
      if (we_cmode)
        cmode_ff <= sso_cmode_t'(wd[2:0]);
      if (we_hold)
        hold_ff <= wd[15:0];
    end
  end

  // Speed thresholds
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rot_ff   <= ROT_RST;
      match_ff <= MATCH_RST;
      arr_ff   <= ARR_RST;
    end else begin
      if (we_rot)
        rot_ff <= wd[9:0];
      if (we_match)
        match_ff <= wd[9:0];
      if (we_arr)
        arr_ff <= wd[13:0];
    end
  end

  // ****************************************************************
  // Settle judgement
  // ****************************************************************
  logic [31:0] abs_dev;   // Magnitude of deviation
  logic [15:0] hold_cnt_ff; // Remaining hold, ms
  logic        ms_tick;   // Millisecond pulse
  logic        settled_ff;

  assign abs_dev = motion.pos_dev[31] ? 32'(-motion.pos_dev) : motion.pos_dev;

  wire logic dev_ok  = abs_dev < {16'h0000, thr_ff};
  wire logic cmd_ok  = dev_ok && (motion.pos_cmd == 32'sh0);
  wire logic filt_ok = dev_ok && (motion.pos_cmd_filt == 32'sh0);
  // Modes 4 to 7 add the zero-speed demand to modes 0 to 3
  wire logic zs_ok   = !cmode_ff[2] || motion.zero_speed;
  wire logic hold_md = (cmode_ff == CM_CMD_HOLD) || (cmode_ff == CM_HOLD_ZS);
  logic base_ok;  // Condition of the low two mode bits

  // Choose the condition for the mode
  always_comb begin
    case (cmode_ff)
      CM_DEV, CM_DEV_ZS:                 base_ok = dev_ok;
      CM_CMD, CM_CMD_ZS:                 base_ok = cmd_ok;
      CM_CMD_HOLD, CM_HOLD_ZS:           base_ok = cmd_ok;
      CM_FILT, CM_FILT_ZS:               base_ok = filt_ok;
      default:                           base_ok = 1'b0;
    endcase
  end

  wire logic cond_ok = base_ok && zs_ok;
  // Hold counter reloads while the condition stands, then runs down
  wire logic [15:0] nxt_hold_cnt =
    (cond_ok && hold_md) ? hold_ff :
    (!hold_md) ? 16'h0000 :
    (ms_tick && hold_cnt_ff != 16'h0000) ? hold_cnt_ff - 16'h0001 : hold_cnt_ff;
  wire logic nxt_settled = cond_ok || (hold_md && hold_cnt_ff != 16'h0000);

  sso_ms_tick #(
    .CYC (CYC_PER_MS)
  ) u_ms_tick (
    .mclk   (mclk),
    .resetn (resetn),
    .tick   (ms_tick)
  );

  // Settle flag and hold timer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hold_cnt_ff <= 16'h0000;
      settled_ff  <= 1'b0;
    end else begin
      hold_cnt_ff <= nxt_hold_cnt;
      settled_ff  <= nxt_settled;
    end
  end

  // ****************************************************************
  // Speed flags
  // ****************************************************************
  logic [15:0] abs_spd;    // Magnitude of speed
  logic [16:0] spd_err;    // Speed minus command
  logic [16:0] abs_err;    // Magnitude of speed error
  logic        rot_flag_ff;    // Rotation detected
  logic        match_flag_ff;  // Speed matches command
  logic        arr_flag_ff;    // Speed reached

  assign abs_spd = motion.speed_fb[15] ? 16'(-motion.speed_fb) : motion.speed_fb;
  assign spd_err = 17'(motion.speed_fb) - 17'(motion.speed_ref);
  assign abs_err = spd_err[16] ? 17'(-spd_err) : spd_err;

  wire logic nxt_rot   = abs_spd > {6'h00, rot_ff};
  wire logic nxt_match = motion.speed_mode &&
                         (abs_err <= {7'h00, match_ff});
  wire logic nxt_arr   = abs_spd >= {2'h0, arr_ff};

  // Speed flag registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rot_flag_ff   <= 1'b0;
      match_flag_ff <= 1'b0;
      arr_flag_ff   <= 1'b0;
    end else begin
      rot_flag_ff   <= nxt_rot;
      match_flag_ff <= nxt_match;
      arr_flag_ff   <= nxt_arr;
    end
  end

  // ****************************************************************
  // Output contacts
  // ****************************************************************
  logic [31:0]     status_vec;  // Function states by code
  logic [N_DO-1:0] contact;     // Contacts before the register
  logic [N_DO-1:0] do_ff;

  // Merge own flags into the function map; code 0 is never active
  always_comb begin
    status_vec             = func_status;
    status_vec[0]          = 1'b0;
    status_vec[FN_ROT]     = rot_flag_ff;
    status_vec[FN_SETTLED] = settled_ff;
    status_vec[FN_MATCH]   = match_flag_ff;
    status_vec[FN_ARR]     = arr_flag_ff;
  end

  sso_out_map #(
    .N (N_DO)
  ) u_out_map (
    .status  (status_vec),
    .fsel    (fsel_act_ff),
    .pol     (pol_ff),
    .contact (contact)
  );

  // ****************************************************************
  // Input function defaults
  // ****************************************************************
  wire logic [31:0] dflt = {hmask_act_ff, lmask_act_ff[15:1], 1'b0};
  wire logic [31:0] nxt_infn = ((input_assigned & input_level) |
                                (~input_assigned & dflt)) & 32'hFFFF_FFFE;
  logic [31:0] infn_ff;

  // Contacts and input functions
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      do_ff   <= '0;
      infn_ff <= 32'h0000_0000;
    end else begin
      do_ff   <= contact;
      infn_ff <= nxt_infn;
    end
  end

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  wire logic [N_EV-1:0] flags = {arr_flag_ff, match_flag_ff, rot_flag_ff, settled_ff};
  logic [N_EV-1:0] flags_d_ff;  // Flags one cycle ago
  wire logic [N_EV-1:0] rise = flags & ~flags_d_ff;
  // A rise in the clearing cycle still sets the bit
  wire logic [N_EV-1:0] nxt_istat =
    (istat_ff & ~(we_istat ? wd[N_EV-1:0] : '0)) | rise;

  // Sticky status, mask and level interrupt
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags_d_ff <= '0;
      istat_ff   <= '0;
      imask_ff   <= '0;
      irq_ff     <= 1'b0;
    end else begin
      flags_d_ff <= flags;
      istat_ff   <= nxt_istat;
      if (we_imask)
        imask_ff <= wd[N_EV-1:0];
      irq_ff <= |(nxt_istat & (we_imask ? wd[N_EV-1:0] : imask_ff));
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [31:0] rmux;  // Selected read word

  // Select the read word; unmapped reads give zero
  always_comb begin
    rmux = 32'h0000_0000;
    for (int i = 0; i < N_DO; i++) begin
      if (addr == OFS_FSEL0 + 8'(i * FSEL_STEP))
        rmux = {27'h0, fsel_ff[i]};
    end
    case (addr)
      OFS_POL:   rmux = {27'h0, pol_ff};
      OFS_LMASK: rmux = {16'h0, lmask_ff};
      OFS_HMASK: rmux = {16'h0, hmask_ff};
      OFS_THR:   rmux = {16'h0, thr_ff};
      OFS_CMODE: rmux = {29'h0, cmode_ff};
      OFS_HOLD:  rmux = {16'h0, hold_ff};
      OFS_ROT:   rmux = {22'h0, rot_ff};
      OFS_MATCH: rmux = {22'h0, match_ff};
      OFS_ARR:   rmux = {18'h0, arr_ff};
      OFS_ISTAT: rmux = {28'h0, istat_ff};
      OFS_IMASK: rmux = {28'h0, imask_ff};
      OFS_STATE: rmux = {23'h0, do_ff, flags};
      default:   ;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      rdata_ff <= 32'h0000_0000;
    else
      rdata_ff <= reg_req.rd ? rmux : 32'h0000_0000;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata                 = rdata_ff;
  assign input_function        = infn_ff;
  assign digital_output        = do_ff;
  assign position_settled_flag = settled_ff;
  assign rotation_detect_flag  = rot_flag_ff;
  assign speed_match_flag      = match_flag_ff;
  assign speed_arrival_flag    = arr_flag_ff;
  assign irq                   = irq_ff;

endmodule // sso_top
`default_nettype wire

// File: sim/sso_relay.sv
// Relay partner on the five output contacts.
// Assumes a contact level of 1 energises the coil.
`timescale 1ns/100ps
`default_nettype none
module sso_relay (
  input  wire logic [4:0] contact,
  output var  logic [4:0] closed
);
  // Energised coil closes the normally-open contact
  assign closed = contact;
endmodule  // sso_relay
`default_nettype wire

// File: sim/sso_top_props.sv
// Port checker of sso_top, bound from the bench.
// Assumes one clock domain, mclk, with resetn low active.
`timescale 1ns/100ps
`default_nettype none
module sso_props (
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire sso_pkg::sso_reg_req_t reg_req,
  input wire logic [31:0]           rdata,
  input wire sso_pkg::sso_motion_t  motion,
  input wire logic [31:0]           input_assigned,
  input wire logic [31:0]           input_level,
  input wire logic [31:0]           input_function,
  input wire logic                  position_settled_flag,
  input wire logic                  rotation_detect_flag,
  input wire logic                  speed_match_flag,
  input wire logic                  irq
);
  import sso_pkg::*;
  // ****
  // Port relations
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> rdata == 32'h0)
    else $error("rdata not idle");
  a_unmapped_zero: assert property ($past(reg_req.rd && reg_req.addr == 8'h80) |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_infn_bit0: assert property (input_function[0] == 1'b0)
    else $error("input function bit 0 set");
  a_infn_driven: assert property (((input_function ^ $past(input_level))
    & $past(input_assigned) & 32'hFFFFFFFE) == 32'h0)
    else $error("driven input function wrong");
  a_settle_range: assert property ($rose(position_settled_flag) |->
    ($past(motion.pos_dev) < 65536 && $past(motion.pos_dev) > -65536))
    else $error("settled with large deviation");
  a_rot_speed: assert property (rotation_detect_flag |-> $past(motion.speed_fb) != 0)
    else $error("rotation flag at zero speed");
  a_match_mode: assert property (speed_match_flag |-> $past(motion.speed_mode))
    else $error("speed match outside speed mode");
  a_irq_masked: assert property (reg_req.wr && reg_req.addr == OFS_IMASK && reg_req.wdata[3:0] == 4'h0
    ##1 !reg_req.wr |=> !irq)
    else $error("irq with mask clear");
endmodule  // sso_props
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench of sso_top with the relay partner.
// Assumes sso_pkg, sso_top, sso_props and sso_relay compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sso_pkg::*;
  logic mclk, resetn, settled, rot, match, arr, irq, e;
  sso_reg_req_t reg_req;
  sso_motion_t  motion;
  logic [31:0]  rdata, func_status, input_assigned, input_level, input_function, v;
  logic [4:0]   digital_output, closed;
  int           fails = 0;
  int           tests_run = 0;
  // Register addresses and reset values, speeds and flag triples
  logic [7:0]  ra [11] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h2C, 8'h30, 8'h34};
  logic [31:0] rv [11] = '{4, 7, 2, 9, 0, 0, 0, 100, 20, 50, 100};
  logic signed [15:0] sp [5] = '{21, 20, 150, 99, 150};
  logic [2:0]  fl [5] = '{3'h4, 3'h0, 3'h7, 3'h6, 3'h5};
  // ****
  // Clock, design and partner
  // ****
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  sso_top #(.CYC_PER_MS(4)) uut (.mclk(mclk), .resetn(resetn), .reg_req(reg_req), .rdata(rdata),
    .motion(motion), .func_status(func_status), .input_assigned(input_assigned),
    .input_level(input_level), .input_function(input_function), .digital_output(digital_output),
    .position_settled_flag(settled), .rotation_detect_flag(rot), .speed_match_flag(match),
    .speed_arrival_flag(arr), .irq(irq));
  sso_relay relay (.contact(digital_output), .closed(closed));
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    reg_req.wr <= 1'b0;
  endtask
  // One-cycle read strobe; data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    reg_req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    print_verdict();
  end
  // ****
  // Test sequence
  // ****
  initial begin
    resetn = 1'b0;
    reg_req = '0;
    func_status = 32'h10;
    input_assigned = 32'h0;
    input_level = 32'h0;
    motion = '{50, 1, 0, 1'b0, 16'sd0, 16'sd100, 1'b1};
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(v, rv[i]);
    end
    rd(8'h80);
    chk(v, 32'h0);
    wr(8'h40, 32'h0);
    step(2);
    chk({27'h0, closed}, 32'h2);
    wr(8'h14, 32'h2);
    step(2);
    chk({27'h0, closed}, 32'h0);
    wr(8'h00, 32'h4);
    step(2);
    chk({27'h0, closed}, 32'h0);
    wr(8'h38, 32'h1);
    step(2);
    chk({27'h0, closed}, 32'h1);
    wr(8'h18, 32'hFFFF);
    wr(8'h1C, 32'h1);
    wr(8'h38, 32'h1);
    @(posedge mclk);
    input_assigned <= 32'h8;
    step(2);
    chk(input_function, 32'h0001FFF6);
    // All eight modes: command moving, then also at zero speed, then command still
    // with the filtered command still moving
    for (int m = 0; m < 24; m++) begin
      @(posedge mclk);
      motion.pos_cmd <= (m > 15) ? 0 : 1;
      motion.pos_cmd_filt <= (m > 15) ? 1 : 0;
      motion.zero_speed <= (m > 7);
      wr(8'h24, 32'(m));
      step(4);
      e = ((m[1:0] == 0) | ((m[1:0] == 3) & (m < 16)) |
           (((m[1:0] == 1) | (m[1:0] == 2)) & (m > 15))) & (~m[2] | (m > 7));
      chk({31'h0, settled}, {31'h0, e});
    end
    wr(8'h28, 32'h2);
    wr(8'h24, 32'h2);
    step(3);
    @(posedge mclk);
    motion.pos_cmd <= 1;
    step(2);
    chk({31'h0, settled}, 32'h1);
    step(30);
    chk({31'h0, settled}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h40, 32'h1);
    step(2);
    chk({31'h0, irq}, 32'h1);
    rd(8'h3C);
    chk(v, 32'h1);
    wr(8'h3C, 32'h1);
    step(2);
    chk({31'h0, irq}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      motion.speed_fb <= sp[i];
      motion.speed_mode <= (i < 4);
      step(3);
      chk({29'h0, rot, match, arr}, {29'h0, fl[i]});
    end
    print_verdict();
  end
endmodule  // testbench
bind sso_top sso_props u_props (.mclk(mclk), .resetn(resetn), .reg_req(reg_req), .rdata(rdata),
  .motion(motion), .input_assigned(input_assigned), .input_level(input_level),
  .input_function(input_function), .position_settled_flag(position_settled_flag),
  .rotation_detect_flag(rotation_detect_flag), .speed_match_flag(speed_match_flag), .irq(irq));
`default_nettype wire
